// >>> hw/ppc_regs.svh
`ifndef PPC_REGS_SVH
`define PPC_REGS_SVH
// ----------------------------------------
// Register offsets
// ----------------------------------------
`define PPC_CTRL_OFFSET   4'h0
`define PPC_STAT_OFFSET   4'h1
`define PPC_OUT_OFFSET    4'h2
// ----------------------------------------
// Control field positions
// ----------------------------------------
`define PPC_MOD_EN_BIT    15
`define PPC_IDLE_BIT      13
`define PPC_MUX_HI_BIT    12
`define PPC_MUX_LO_BIT    11
`define PPC_BE_EN_BIT     10
`define PPC_WR_EN_BIT     9
`define PPC_RD_EN_BIT     8
`define PPC_CSF_HI_BIT    7
`define PPC_CSF_LO_BIT    6
`define PPC_ALP_BIT       5
`define PPC_CHIP_SELECT1_POLARITY_BIT      3
`define PPC_BEP_BIT       2
`define PPC_WRSP_BIT      1
`define PPC_RDSP_BIT      0
// ----------------------------------------
// Reset values and masks
// ----------------------------------------
`define PPC_CTRL_RESET    16'h0000
`define PPC_CTRL_WMASK    16'hBFEF
`define PPC_OUT_RESET     16'h0000
`define PPC_CSF_CHIPSEL   2'h2
`endif

// >>> hw/ppc_pkg.sv
package ppc_pkg;
  typedef enum logic [1:0] {
    PPC_MUX_NONE = 2'h0,
    PPC_MUX_LOW  = 2'h1,
    PPC_MUX_FULL = 2'h2,
    PPC_MUX_RSVD = 2'h3
  } ppc_mux_type;

  typedef struct packed {
    logic be;
    logic wr;
    logic rd;
    logic cs1;
    logic all;
    logic alh;
  } ppc_pins_type;

  typedef struct packed {
    logic [15:0]  ctrl;
    logic [15:0]  drive;
    logic [15:0]  rdata;
    ppc_pins_type pin_val;
    ppc_pins_type pin_oe;
  } ppc_state_type;
endpackage

// >>> hw/ppc_top.sv
`timescale 1ns/100ps
`include "ppc_regs.svh"
module ppc_top (
  // Clock and reset
  input  wire logic                sys_clk_in,
  input  wire logic                rst_n_in,
  // Register port
  input  wire logic [3:0]          reg_addr_in,
  input  wire logic [15:0]         reg_wdata_in,
  input  wire logic                reg_wr_in,
  input  wire logic                reg_rd_in,
  output logic      [15:0]         reg_rdata_out,
  // Pin usage and idle
  input  wire logic                cs1_as_addr_in,
  input  wire logic                idle_in,
  // Pins
  output ppc_pkg::ppc_pins_type    pin_val_out,
  output ppc_pkg::ppc_pins_type    pin_oe_out,
  output logic                     mod_active_out,
  output ppc_pkg::ppc_mux_type     mux_mode_out
);
  ppc_pkg::ppc_state_type state_ff;
  ppc_pkg::ppc_state_type nxt_state;

  // ----------------------------------------
  // Polarity helper
  // ----------------------------------------
  function automatic logic pol(input logic act, input logic high);
    pol = high ? act : ~act;
  endfunction

  // ----------------------------------------
  // Mux decode helpers
  // ----------------------------------------
  function automatic logic lat_lo_on(input logic [1:0] m);
    lat_lo_on = (m == 2'h1) || (m == 2'h2);
  endfunction
  function automatic logic lat_hi_on(input logic [1:0] m);
    lat_hi_on = (m == 2'h2);
  endfunction

  // ----------------------------------------
  // Next state
  // ----------------------------------------
  logic [15:0] c;
  logic [15:0] dv;
  logic        run;
  always_comb begin
    nxt_state = state_ff;
    c         = state_ff.ctrl;
    dv        = state_ff.drive;
    // ----------------------------------------
    // Register writes
    // ----------------------------------------
    // Bit 4 never stored
    // write mask
    if (reg_wr_in && reg_addr_in == `PPC_CTRL_OFFSET) begin
      c = reg_wdata_in & `PPC_CTRL_WMASK;
    end
    if (reg_wr_in && reg_addr_in == `PPC_OUT_OFFSET) begin
      dv = reg_wdata_in;
    end
    nxt_state.ctrl  = c;
    nxt_state.drive = dv;
    run = c[`PPC_MOD_EN_BIT] & ~(c[`PPC_IDLE_BIT] & idle_in);
    // ----------------------------------------
    // Register reads
    // ----------------------------------------
    nxt_state.rdata = 16'h0000;
    if (reg_rd_in) begin
      case (reg_addr_in)
        `PPC_CTRL_OFFSET: nxt_state.rdata = state_ff.ctrl;
        `PPC_STAT_OFFSET: nxt_state.rdata = {10'h000, mod_active_out, 3'h0, mux_mode_out};
        `PPC_OUT_OFFSET:  nxt_state.rdata = state_ff.drive;
        default:          nxt_state.rdata = 16'h0000;
      endcase
    end
    // ----------------------------------------
    // Strobe pins
    // ----------------------------------------
    // byte enable
    nxt_state.pin_oe.be  = run & c[`PPC_BE_EN_BIT];
    nxt_state.pin_val.be = nxt_state.pin_oe.be & pol(dv[0], c[`PPC_BEP_BIT]);
    nxt_state.pin_oe.wr  = run & c[`PPC_WR_EN_BIT];
    nxt_state.pin_val.wr = nxt_state.pin_oe.wr & pol(dv[1], c[`PPC_WRSP_BIT]);
    nxt_state.pin_oe.rd  = run & c[`PPC_RD_EN_BIT];
    nxt_state.pin_val.rd = nxt_state.pin_oe.rd & pol(dv[2], c[`PPC_RDSP_BIT]);
    // ----------------------------------------
    // Chip select pin
    // ----------------------------------------
    // chip select polarity
    nxt_state.pin_oe.cs1 = run;
    if (cs1_as_addr_in || c[`PPC_CSF_HI_BIT:`PPC_CSF_LO_BIT] != `PPC_CSF_CHIPSEL) begin
      nxt_state.pin_val.cs1 = run & dv[3];
    end else begin
      nxt_state.pin_val.cs1 = run & pol(dv[3], c[`PPC_CHIP_SELECT1_POLARITY_BIT]);
    end
    // ----------------------------------------
    // Address latch pins
    // ----------------------------------------
    // latch polarity
    nxt_state.pin_oe.all  = run & lat_lo_on(c[`PPC_MUX_HI_BIT:`PPC_MUX_LO_BIT]);
    nxt_state.pin_oe.alh  = run & lat_hi_on(c[`PPC_MUX_HI_BIT:`PPC_MUX_LO_BIT]);
    nxt_state.pin_val.all = nxt_state.pin_oe.all & pol(dv[4], c[`PPC_ALP_BIT]);
    nxt_state.pin_val.alh = nxt_state.pin_oe.alh & pol(dv[5], c[`PPC_ALP_BIT]);
  end

  // ----------------------------------------
  // Registered state
  // ----------------------------------------

  always_ff @(posedge sys_clk_in) begin
    if (!rst_n_in) begin
      state_ff <= '0;
    end else begin
      state_ff <= nxt_state;
    end
  end

  // ----------------------------------------
  // Outputs
  // ----------------------------------------
  logic        act_ff;
  ppc_pkg::ppc_mux_type mux_ff;
  always_ff @(posedge sys_clk_in) begin
    if (!rst_n_in) begin
      act_ff <= 1'b0;
      mux_ff <= ppc_pkg::PPC_MUX_NONE;
    end else begin
      act_ff <= run;
      mux_ff <= ppc_pkg::ppc_mux_type'(c[`PPC_MUX_HI_BIT:`PPC_MUX_LO_BIT]);
    end
  end
  assign reg_rdata_out  = state_ff.rdata;
  assign pin_val_out    = state_ff.pin_val;
  assign pin_oe_out     = state_ff.pin_oe;
  assign mod_active_out = act_ff;
  assign mux_mode_out   = mux_ff;

  // ----------------------------------------
  // Assertions
  // ----------------------------------------
  default clocking cb @(posedge sys_clk_in); endclocking
  default disable iff (!rst_n_in);
  // ----------------------------------------
  // Pin enables
  // ----------------------------------------
  a_be_oe_set: assert property (state_ff.ctrl[10] && mod_active_out |-> pin_oe_out.be)
    else $error("byte enable not driven while enabled");
  a_be_off_val: assert property (!pin_oe_out.be |-> !pin_val_out.be)
    else $error("byte enable level while released");
  a_wr_oe_set: assert property (state_ff.ctrl[9] && mod_active_out |-> pin_oe_out.wr)
    else $error("write strobe not driven while enabled");
  a_rd_oe_set: assert property (state_ff.ctrl[8] && mod_active_out |-> pin_oe_out.rd)
    else $error("read strobe not driven while enabled");
  a_be_oe_follow: assert property (pin_oe_out.be |-> state_ff.ctrl[10])
    else $error("byte enable driven while disabled");
  a_wr_oe_follow: assert property (pin_oe_out.wr |-> state_ff.ctrl[9])
    else $error("write strobe driven while disabled");
  a_rd_oe_follow: assert property (!state_ff.ctrl[8] |-> !pin_oe_out.rd)
    else $error("read strobe driven while disabled");
  // ----------------------------------------
  // Polarity
  // ----------------------------------------
  a_alp_low: assert property (pin_oe_out.all && !state_ff.ctrl[5] |-> pin_val_out.all == ~state_ff.drive[4])
    else $error("latch polarity wrong");
  a_alp_high: assert property (pin_oe_out.all && state_ff.ctrl[5] |-> pin_val_out.all == state_ff.drive[4])
    else $error("latch high polarity wrong");
  a_alh_pol: assert property (pin_oe_out.alh |->
    pin_val_out.alh == (state_ff.ctrl[5] ? state_ff.drive[5] : ~state_ff.drive[5]))
    else $error("high latch polarity wrong");
  a_cs_pol_hi: assert property (pin_oe_out.cs1 && !cs1_as_addr_in && state_ff.ctrl[3] && state_ff.ctrl[7:6] == 2'h2
    && $stable(cs1_as_addr_in) |-> pin_val_out.cs1 == state_ff.drive[3])
    else $error("chip select high polarity wrong");
  a_cs_other_fn: assert property (pin_oe_out.cs1 && state_ff.ctrl[7:6] != 2'h2 |->
    pin_val_out.cs1 == state_ff.drive[3])
    else $error("polarity applied outside chip select use");
  a_cs_pol: assert property (pin_oe_out.cs1 && !cs1_as_addr_in && !state_ff.ctrl[3] && state_ff.ctrl[7:6] == 2'h2
    && $stable(cs1_as_addr_in) |-> pin_val_out.cs1 == ~state_ff.drive[3])
    else $error("chip select polarity wrong");
  a_cs_addr: assert property ($past(cs1_as_addr_in) && pin_oe_out.cs1 && $stable(state_ff.drive)
    |-> pin_val_out.cs1 == state_ff.drive[3])
    else $error("polarity applied to address pin");
  // ----------------------------------------
  // Register port
  // ----------------------------------------
  a_bit4_zero: assert property (reg_rd_in && reg_addr_in == 4'h0 |=> reg_rdata_out[4] == 1'b0)
    else $error("bit 4 read nonzero");
  a_bit4_store: assert property (state_ff.ctrl[4] == 1'b0)
    else $error("bit 4 stored");
  // ----------------------------------------
  // Multiplexing
  // ----------------------------------------
  a_mux_track: assert property (reg_wr_in && reg_addr_in == 4'h0 |=> mux_mode_out == $past(reg_wdata_in[12:11]))
    else $error("mux mode not updated");
  a_lat_rsvd: assert property (state_ff.ctrl[12:11] == 2'h3 |-> !pin_oe_out.all && !pin_oe_out.alh)
    else $error("latch driven in reserved mode");
  a_lat_lo_on: assert property (mod_active_out && lat_lo_on(state_ff.ctrl[12:11]) |-> pin_oe_out.all)
    else $error("low latch not driven");
  a_alh_full: assert property (pin_oe_out.alh |-> lat_hi_on(state_ff.ctrl[12:11]))
    else $error("high latch driven outside full mux");
  c_be_on:  cover property (pin_oe_out.be);
  c_cs_hi:  cover property (pin_oe_out.cs1 && state_ff.ctrl[3]);
  c_mux_2:  cover property (mux_mode_out == ppc_pkg::PPC_MUX_FULL);
  c_cs_adr: cover property (pin_oe_out.cs1 && $past(cs1_as_addr_in));
  c_idle:   cover property (state_ff.ctrl[15] && state_ff.ctrl[13] && !mod_active_out);
endmodule

// >>> verif/ppc_far_model.sv
`timescale 1ns/100ps
module ppc_far_model (
  // Pins from port
  input  wire ppc_pkg::ppc_pins_type pin_val_in,
  input  wire ppc_pkg::ppc_pins_type pin_oe_in,
  // Levels seen by peripheral
  output logic [5:0]                 line_out
);
  // ----------------------------------------
  // Released pins float to pull-up
  // ----------------------------------------
  assign line_out = (pin_val_in & pin_oe_in) | ~pin_oe_in;
endmodule

// >>> verif/tb_top.sv
`timescale 1ns/100ps
module tb_top;
  logic                  sys_clk_in, rst_n_in, reg_wr_in, reg_rd_in, cs1_as_addr_in, idle_in, mod_active_out;
  logic [3:0]            reg_addr_in;
  logic [15:0]           reg_wdata_in, reg_rdata_out, c, d;
  ppc_pkg::ppc_pins_type pin_val_out, pin_oe_out;
  ppc_pkg::ppc_mux_type  mux_mode_out;
  logic [5:0]            line_lvl, eo, ev, pol;
  int                    mismatches, samples_checked, seed, i, j;
  ppc_top i_ppc_top (.sys_clk_in(sys_clk_in), .rst_n_in(rst_n_in), .reg_addr_in(reg_addr_in),
    .reg_wdata_in(reg_wdata_in), .reg_wr_in(reg_wr_in), .reg_rd_in(reg_rd_in), .reg_rdata_out(reg_rdata_out),
    .cs1_as_addr_in(cs1_as_addr_in), .idle_in(idle_in), .pin_val_out(pin_val_out), .pin_oe_out(pin_oe_out),
    .mod_active_out(mod_active_out), .mux_mode_out(mux_mode_out));
  ppc_far_model i_ppc_far_model (.pin_val_in(pin_val_out), .pin_oe_in(pin_oe_out), .line_out(line_lvl));
  // ----------------------------------------
  // Clock, bus and compare tasks
  // ----------------------------------------
  initial begin
    sys_clk_in = 1'b0;
    forever #20 sys_clk_in = ~sys_clk_in;
  end
  task automatic op(input logic w, input logic r, input logic [3:0] a, input logic [15:0] v);
    @(posedge sys_clk_in);
    reg_wr_in    <= w;
    reg_rd_in    <= r;
    reg_addr_in  <= a;
    reg_wdata_in <= v;
  endtask
  task automatic chk(input string n, input logic [15:0] e, input logic [15:0] g);
    samples_checked++;
    if (e !== g) begin
      mismatches++;
      $display("wrong value %s expected %h seen %h", n, e, g);
    end
  endtask
  task automatic rd_chk(input logic [3:0] a, input logic [15:0] e);
    op(1'b0, 1'b1, a, 16'h0000);
    op(1'b0, 1'b0, 4'h0, 16'h0000);
    #1 chk("rdata", e, reg_rdata_out);
  endtask
  task automatic final_report;
    $display("mismatches %0d samples_checked %0d", mismatches, samples_checked);
    if (mismatches == 0 && samples_checked > 0) $display("All tests passed");
    else $display("Some tests failed");
    $finish;
  endtask
  initial begin
    repeat (5000) @(posedge sys_clk_in);
    mismatches++;
    final_report;
  end
  // ----------------------------------------
  // Random control and drive sweeps
  // ----------------------------------------
  initial begin
    {rst_n_in, reg_wr_in, reg_rd_in, cs1_as_addr_in, idle_in} = 5'h00;
    reg_addr_in  = 4'h0;
    reg_wdata_in = 16'h0000;
    seed         = 32'h20A4;
    repeat (3) @(posedge sys_clk_in);
    rst_n_in <= 1'b1;
    #1 chk("active", 16'h0000, {15'h0000, mod_active_out});
    rd_chk(4'h7, 16'h0000);
    for (i = 0; i < 60; i++) begin
      c = $random(seed);
      d = $random(seed);
      op(1'b1, 1'b0, 4'h0, c);
      op(1'b1, 1'b0, 4'h2, d);
      cs1_as_addr_in <= d[8];
      idle_in        <= d[9];
      op(1'b1, 1'b0, 4'h9, 16'hFFFF);
      op(1'b0, 1'b0, 4'h0, 16'h0000);
      repeat (3) @(posedge sys_clk_in);
      rd_chk(4'h0, c & 16'hBFEF);
      chk("active", {15'h0000, c[15] & ~(c[13] & d[9])}, {15'h0000, mod_active_out});
      chk("mux", {14'h0000, c[12:11]}, {14'h0000, mux_mode_out});
      pol = {c[2], c[1], c[0], c[3], c[5], c[5]};
      for (j = 0; j < 6; j++) ev[5 - j] = d[j] ? pol[5 - j] : ~pol[5 - j];
      if (!(c[7:6] == 2'h2 && !d[8])) ev[2] = d[3];
      eo = {c[10], c[9], c[8], 1'b1, (c[12:11] == 2'h1) || (c[12:11] == 2'h2), c[12:11] == 2'h2};
      eo = eo & {6{c[15] & ~(c[13] & d[9])}};
      chk("oe", {10'h000, eo}, {10'h000, pin_oe_out});
      chk("val", {10'h000, ev & eo}, {10'h000, pin_val_out});
      chk("lines", {10'h000, (ev & eo) | ~eo}, {10'h000, line_lvl});
    end
    rst_n_in <= 1'b0;
    repeat (3) @(posedge sys_clk_in);
    rst_n_in <= 1'b1;
    #1 chk("oe", 16'h0000, {10'h000, pin_oe_out});
    rd_chk(4'h0, 16'h0000);
    final_report;
  end
endmodule
